// >>> core/mwsh_pkg.sv
// Constants and carrier types for the management watchdog and sensor health block.
// Assumes a single 100 MHz management clock and a synchronous active-low reset.
package mwsh_pkg;
	// Clock and timing
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned WD_TIMEOUT_US = 1000000;
	localparam int unsigned WD_TIMEOUT_CYC = WD_TIMEOUT_US * CLK_MHZ;
	localparam int unsigned WD_STROBE_US = 500;
	localparam int unsigned WD_CNT_W = 27;
	localparam int unsigned RST_HOLD_CYC = 16;
	localparam int unsigned SCAN_TICK_NS = 1000;
	localparam int unsigned SCAN_DIV_CYC = SCAN_TICK_NS / CLK_PERIOD_NS;

	// Management bus identity
	localparam logic [7:0] TARGET_ADDR = 8'hA6;

	// Sensor population
	localparam int unsigned NUM_SENSORS = 29;
	localparam logic [28:0] PAYLOAD_ONLY_MASK = 29'h0E3FC000;
	localparam logic [28:0] HEALTH_LED_MASK = 29'h0E3FFF00;
	localparam logic [4:0] LINK_SENSOR_ID = 5'h04;
	localparam logic [4:0] LAST_SENSOR_ID = 5'h1C;

	// Inventory store
	localparam int unsigned FRU_BYTES = 4096;
	localparam int unsigned FRU_AW = 13;

	typedef enum logic [1:0] {
		WD_RUN = 2'b01,
		WD_HOLD = 2'b10
	} mwsh_wd_state_e;

	typedef struct packed {
		logic [7:0] owner;
		logic [4:0] sensor;
		logic asserted;
	} mwsh_event_s;
endpackage

// >>> core/mwsh_top.sv
// Watchdog supervisor, sensor scan with health indicator, event source and bus identity.
// Assumes all inputs are synchronous to ref_clk and the event sink obeys valid/ready.
`timescale 1ns/100ps
module mwsh_top #(
	parameter int unsigned WD_TIMEOUT_CYC = mwsh_pkg::WD_TIMEOUT_CYC
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic wd_strobe,
	output logic mgmt_rst_b,
	input wire logic payload_on,
	input wire logic [28:0] sensor_alarm,
	input wire logic link_fail,
	output logic health_amber,
	output logic ev_valid,
	input wire logic ev_ready,
	output mwsh_pkg::mwsh_event_s ev,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_addr,
	output logic addr_hit,
	input wire logic upd_commit,
	input wire logic upd_fail,
	output logic active_img,
	input wire logic [12:0] fru_addr,
	output logic fru_addr_ok
);

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog supervisor

	mwsh_pkg::mwsh_wd_state_e wd_state;
	logic [26:0] wd_cnt;
	logic [4:0] hold_cnt;
	logic strobe_prev;
	logic strobe_edge;

	// Strobe edge; a stuck-high strobe line does not keep the controller alive
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			strobe_prev <= 1'b0;
		end else begin
			strobe_prev <= wd_strobe;
		end
	end
	assign strobe_edge = wd_strobe & ~strobe_prev;

	// Fixed timeout, no configuration path by design
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			wd_state <= mwsh_pkg::WD_RUN;
			wd_cnt <= 27'h0000000;
			hold_cnt <= 5'h00;
			mgmt_rst_b <= 1'b1;
		end else begin
			unique case (wd_state)
				mwsh_pkg::WD_RUN: begin
					if (strobe_edge) begin
						wd_cnt <= 27'h0000000;
					end else if (wd_cnt == 27'(WD_TIMEOUT_CYC - 1)) begin
						wd_state <= mwsh_pkg::WD_HOLD;
						mgmt_rst_b <= 1'b0;
						hold_cnt <= 5'h00;
					end else begin
						wd_cnt <= wd_cnt + 27'h0000001;
					end
				end
				mwsh_pkg::WD_HOLD: begin
					wd_cnt <= 27'h0000000;
					if (hold_cnt == 5'(mwsh_pkg::RST_HOLD_CYC - 1)) begin
						wd_state <= mwsh_pkg::WD_RUN;
						mgmt_rst_b <= 1'b1;
					end else begin
						hold_cnt <= hold_cnt + 5'h01;
					end
				end
				default: begin
					wd_state <= mwsh_pkg::WD_RUN;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sensor scan

	logic [6:0] div_cnt;
	logic scan_tick;
	logic [4:0] scan_idx;
	logic [28:0] alarm_state;
	logic link_pend;
	logic scan_active;
	logic scan_change;
	logic link_send;
	logic scan_send;

	// Scan rate divider: one sensor per tick keeps the event rate bounded
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			div_cnt <= 7'h00;
			scan_tick <= 1'b0;
		end else if (div_cnt == 7'(mwsh_pkg::SCAN_DIV_CYC - 1)) begin
			div_cnt <= 7'h00;
			scan_tick <= 1'b1;
		end else begin
			div_cnt <= div_cnt + 7'h01;
			scan_tick <= 1'b0;
		end
	end

	// Payload sensors are skipped with payload power off
	assign scan_active = payload_on | ~mwsh_pkg::PAYLOAD_ONLY_MASK[scan_idx];
	assign scan_change = scan_active & (sensor_alarm[scan_idx] != alarm_state[scan_idx]);
	// Link recovery wins over a scan event; the scan simply waits a tick
	assign link_send = link_pend & ~link_fail & ~ev_valid;
	assign scan_send = scan_tick & scan_change & ~ev_valid & ~link_send;

	// Scan index advances only once a changed sensor has been reported
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			scan_idx <= 5'h00;
		end else if (scan_tick & (~scan_change | scan_send)) begin
			scan_idx <= (scan_idx == mwsh_pkg::LAST_SENSOR_ID) ? 5'h00 : scan_idx + 5'h01;
		end
	end

	// Latched alarm picture, updated as each change is reported
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			alarm_state <= 29'h00000000;
		end else if (scan_send) begin
			alarm_state[scan_idx] <= sensor_alarm[scan_idx];
		end
	end

	// Health indicator follows alarms of indicator-bearing sensors only
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			health_amber <= 1'b0;
		end else begin
			health_amber <= |(alarm_state & mwsh_pkg::HEALTH_LED_MASK);
		end
	end

	// Link failure is remembered and reported after recovery; a new failure sets over the send
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			link_pend <= 1'b0;
		end else if (link_fail) begin
			link_pend <= 1'b1;
		end else if (link_send) begin
			link_pend <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Event source towards the front board

	// Event stands until taken by the front board side
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			ev_valid <= 1'b0;
			ev <= '0;
		end else if (link_send) begin
			ev_valid <= 1'b1;
			ev.owner <= mwsh_pkg::TARGET_ADDR;
			ev.sensor <= mwsh_pkg::LINK_SENSOR_ID;
			ev.asserted <= 1'b1;
		end else if (scan_send) begin
			ev_valid <= 1'b1;
			ev.owner <= mwsh_pkg::TARGET_ADDR;
			ev.sensor <= scan_idx;
			ev.asserted <= sensor_alarm[scan_idx];
		end else if (ev_ready) begin
			ev_valid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus identity, image selection and inventory range

	// Address compare against the fixed target, no strap or register changes it
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			addr_hit <= 1'b0;
		end else begin
			addr_hit <= cmd_valid & (cmd_addr == mwsh_pkg::TARGET_ADDR);
		end
	end

	logic can_revert;

	// Two images; a fail after a commit swaps back to the previous one
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			active_img <= 1'b0;
			can_revert <= 1'b0;
		end else if (upd_fail & can_revert) begin
			active_img <= ~active_img;
			can_revert <= 1'b0;
		end else if (upd_commit) begin
			active_img <= ~active_img;
			can_revert <= 1'b1;
		end
	end

	// Inventory window check
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			fru_addr_ok <= 1'b0;
		end else begin
			fru_addr_ok <= (fru_addr < 13'(mwsh_pkg::FRU_BYTES));
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	wd_expire_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(wd_state == mwsh_pkg::WD_RUN && !strobe_edge && wd_cnt == 27'(WD_TIMEOUT_CYC - 1)) |=> !mgmt_rst_b)
		else $error("watchdog did not reset on expiry");
	strobe_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(wd_state == mwsh_pkg::WD_RUN && strobe_edge) |=> (wd_cnt == 27'h0000000 && mgmt_rst_b))
		else $error("strobe did not restart the count");
	reset_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$fell(mgmt_rst_b) |-> !mgmt_rst_b [*8])
		else $error("controller reset too short");
	restart_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$rose(mgmt_rst_b) |-> wd_cnt == 27'h0000000)
		else $error("count not zero on release");
	fixed_addr_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cmd_valid |=> (addr_hit == ($past(cmd_addr) == 8'hA6)))
		else $error("address match wrong");
	event_owner_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		ev_valid |-> ev.owner == 8'hA6)
		else $error("event owner wrong");
	payload_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		($rose(ev_valid) && ev.sensor != mwsh_pkg::LINK_SENSOR_ID && mwsh_pkg::PAYLOAD_ONLY_MASK[ev.sensor])
		|-> $past(payload_on))
		else $error("payload sensor scanned with power off");
	amber_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(|(alarm_state & mwsh_pkg::HEALTH_LED_MASK)) |=> health_amber)
		else $error("health indicator not amber");
	link_report_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(link_pend && !link_fail && !ev_valid) |=> (ev_valid && ev.sensor == mwsh_pkg::LINK_SENSOR_ID))
		else $error("link recovery not reported");
	event_stand_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(ev_valid && !ev_ready) |=> (ev_valid && $stable(ev)))
		else $error("event dropped before taken");
	image_revert_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(upd_fail && can_revert) |=> (active_img != $past(active_img) && !can_revert))
		else $error("image not reverted");
	fru_range_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(fru_addr == 13'h0FFF) |=> fru_addr_ok)
		else $error("inventory top byte refused");

	wd_fire_c: cover property (@(posedge ref_clk) disable iff (!rst_b) $fell(mgmt_rst_b));
	alarm_event_c: cover property (@(posedge ref_clk) disable iff (!rst_b) ev_valid && ev.asserted && ev_ready);
	link_event_c: cover property (@(posedge ref_clk) disable iff (!rst_b) link_send);
	revert_c: cover property (@(posedge ref_clk) disable iff (!rst_b) upd_fail && can_revert);

endmodule

// >>> bench/mwsh_fb_model.sv
// Front board controller model: event sink with adjustable lag and watchdog strober.
// Assumes ref_clk and rst_b are the ones that drive the block.
`timescale 1ns/100ps
module mwsh_fb_model (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic ev_valid,
	output logic ev_ready,
	input wire logic [3:0] lag,
	input wire logic strobe_en,
	output logic wd_strobe
);
	logic [3:0] wait_cnt;
	logic [5:0] strobe_cnt;

	////////////////////////////////////////////////////////////////
	// Sink: accepts an event after lag cycles, so slow takes are exercised
	always_ff @(posedge ref_clk) begin
		if (!rst_b || !ev_valid || ev_ready) begin
			wait_cnt <= 4'h0;
			ev_ready <= 1'b0;
		end else if (wait_cnt >= lag) begin
			ev_ready <= 1'b1;
		end else begin
			wait_cnt <= wait_cnt + 4'h1;
		end
	end

	// One-cycle strobe every 50 cycles, scaled with the shortened timeout
	always_ff @(posedge ref_clk) begin
		if (!rst_b || !strobe_en) begin
			strobe_cnt <= 6'h00;
			wd_strobe <= 1'b0;
		end else begin
			strobe_cnt <= (strobe_cnt == 6'h31) ? 6'h00 : strobe_cnt + 6'h01;
			wd_strobe <= (strobe_cnt == 6'h31);
		end
	end
endmodule

// >>> bench/test_mwsh_top.sv
// Self-checking bench for the watchdog, sensor events, bus identity, image and inventory.
// Assumes the front board model drives strobe and event ready.
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
	$display("MISMATCH %0t value differs", $time); end end
module test_mwsh_top;
	logic ref_clk = 0, rst_b = 0, payload_on = 0, link_fail = 0, cmd_valid = 0;
	logic upd_commit = 0, upd_fail = 0, strobe_en = 0, wd_strobe, mgmt_rst_b, ev_ready;
	logic health_amber, ev_valid, addr_hit, active_img, fru_addr_ok;
	logic [28:0] sensor_alarm = 29'h0;
	logic [7:0] cmd_addr = 8'h00;
	logic [12:0] fru_addr = 13'h0000;
	logic [3:0] lag = 4'h5;
	mwsh_pkg::mwsh_event_s ev;
	int fail_count = 0, check_count = 0, n;

	mwsh_top #(.WD_TIMEOUT_CYC(200)) uut (.ref_clk(ref_clk), .rst_b(rst_b), .wd_strobe(wd_strobe),
		.mgmt_rst_b(mgmt_rst_b), .payload_on(payload_on), .sensor_alarm(sensor_alarm),
		.link_fail(link_fail), .health_amber(health_amber), .ev_valid(ev_valid), .ev_ready(ev_ready),
		.ev(ev), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .addr_hit(addr_hit),
		.upd_commit(upd_commit), .upd_fail(upd_fail), .active_img(active_img),
		.fru_addr(fru_addr), .fru_addr_ok(fru_addr_ok));
	mwsh_fb_model fb (.ref_clk(ref_clk), .rst_b(rst_b), .ev_valid(ev_valid), .ev_ready(ev_ready),
		.lag(lag), .strobe_en(strobe_en), .wd_strobe(wd_strobe));

	always #5 ref_clk = ~ref_clk;

	////////////////////////////////////////////////////////////////
	task end_of_test;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Waits for the sink to take an event, bounded by a full scan and more
	task wait_ev(input logic [4:0] id, input logic asrt);
		for (n = 0; n < 4000 && !(ev_valid && ev_ready); n++) @(posedge ref_clk);
		if (n == 4000) begin
			fail_count++;
			$display("MISMATCH %0t event wait timed out", $time);
			end_of_test();
		end
		`CHK(ev.owner, 8'hA6)
		`CHK(ev.sensor, id)
		`CHK(ev.asserted, asrt)
		@(posedge ref_clk);
	endtask

	// Flags any event activity over a window; none is expected
	task quiet(input int cyc);
		logic seen;
		seen = 1'b0;
		repeat (cyc) @(posedge ref_clk) seen |= ev_valid;
		`CHK(seen, 1'b0)
	endtask

	// Counts edges until the controller reset shows lvl; a stuck level ends the run
	task wait_rst(input logic lvl, input int lim);
		for (n = 0; n < lim && mgmt_rst_b !== lvl; n++) @(posedge ref_clk);
		if (n == lim) begin
			fail_count++;
			$display("MISMATCH %0t controller reset wait timed out", $time);
			end_of_test();
		end
	endtask

	////////////////////////////////////////////////////////////////
	// Silence expiry time, hold length, then regular strobes keep it alive
	task t_watchdog;
		logic low;
		wait_rst(1'b0, 400);
		`CHK(n inside {[198:202]}, 1'b1)
		wait_rst(1'b1, 40);
		`CHK(n, 16)
		// No strobe after release: a second full timeout shows the count restarted from zero
		wait_rst(1'b0, 400);
		`CHK(n, 200)
		wait_rst(1'b1, 40);
		`CHK(n, 16)
		strobe_en <= 1'b1;
		low = 1'b0;
		repeat (600) @(posedge ref_clk) low |= !mgmt_rst_b;
		`CHK(low, 1'b0)
	endtask

	// Alarm changes become events; only health sensors turn the indicator amber
	task t_events;
		sensor_alarm[9] <= 1'b1;
		wait_ev(5'd9, 1'b1);
		repeat (3) @(posedge ref_clk);
		`CHK(health_amber, 1'b1)
		lag <= 4'h0;
		sensor_alarm[9] <= 1'b0;
		wait_ev(5'd9, 1'b0);
		sensor_alarm[2] <= 1'b1;
		wait_ev(5'd2, 1'b1);
		repeat (3) @(posedge ref_clk);
		`CHK(health_amber, 1'b0)
	endtask

	// Payload-only sensor is ignored until payload power comes on
	task t_payload;
		sensor_alarm[14] <= 1'b1;
		quiet(3200);
		payload_on <= 1'b1;
		wait_ev(5'd14, 1'b1);
	endtask

	// Link failure is reported only after recovery
	task t_link;
		link_fail <= 1'b1;
		quiet(300);
		link_fail <= 1'b0;
		wait_ev(5'd4, 1'b1);
	endtask

	// Fixed address and inventory range, a hit and a miss each; image commit, revert, then a fail with nothing to revert
	task t_misc;
		for (int i = 0; i < 2; i++) begin
			@(posedge ref_clk);
			cmd_valid <= 1'b1;
			cmd_addr <= i ? 8'hA7 : 8'hA6;
			fru_addr <= i ? 13'h1000 : 13'h0FFF;
			@(posedge ref_clk);
			cmd_valid <= 1'b0;
			#1;
			`CHK(addr_hit, !i)
			`CHK(fru_addr_ok, !i)
		end
		for (int i = 0; i < 3; i++) begin
			@(posedge ref_clk);
			upd_commit <= (i == 0);
			upd_fail <= (i != 0);
			@(posedge ref_clk);
			upd_commit <= 1'b0;
			upd_fail <= 1'b0;
			#1;
			`CHK(active_img, i == 0)
		end
	endtask

	initial begin
		repeat (10) @(posedge ref_clk);
		rst_b <= 1'b1;
		t_watchdog();
		t_events();
		t_payload();
		t_link();
		t_misc();
		end_of_test();
	end
endmodule
